// ### test/iack_cpu_model.sv
// stand-in for the cpu core and the pins that surround the block
`timescale 1ns/100ps
module iack_cpu_model
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       step,
  input  wire logic [2:0] pin_lvl,
  output logic [2:0]      ext_irq_pin,
  output logic            fetch_strb,
  output logic            instr_done
);
  logic done_reg;
  // a fetch, then the instruction completes two cycles later
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      fetch_strb  <= 1'b0;
      done_reg    <= 1'b0;
      instr_done  <= 1'b0;
      ext_irq_pin <= 3'h7;
    end
    else
    begin
      fetch_strb  <= step;
      done_reg    <= fetch_strb;
      instr_done  <= done_reg;
      ext_irq_pin <= pin_lvl; // pins are driven, never left floating
    end
  end
endmodule

// ### test/interrupt_acknowledge_and_ext_irq_bench.sv
// self-checking bench for the interrupt acknowledge block
`timescale 1ns/100ps
`include "iack_consts.svh"
module interrupt_acknowledge_and_ext_irq_bench;
  import iack_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [8:0]  adr = 9'h000;
  logic [31:0] dat = 32'h00000000;
  logic        step = 1'b0;
  logic        wdt = 1'b0;
  logic        zdiv = 1'b0;
  logic        break_trap = 1'b0;
  logic [2:0]  pin_lvl = 3'h7;
  logic [31:0] dat_o;
  logic        ack;
  logic [2:0]  pins;
  logic [2:0]  dir;
  logic        fetch;
  logic        done;
  iack_word_t  pc;
  iack_word_t  ps;
  logic [7:0]  bank;
  logic        busy;
  logic        go;
  logic [15:0] q;
  logic [15:0] pc0;
  logic [7:0]  bk0;
  logic [6:0]  sp0;
  logic [2:0]  lvl;
  logic [7:0]  stk [5];
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          nb;

  iack_ctrl iack_ctrl_inst
  (
    .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_sel_i(4'h3), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .ext_irq_pin(pins),
    .fetch_strb(fetch), .instr_done(done), .wdt_irq(wdt),
    .zdiv_trap(zdiv), .brk_trap(break_trap), .code_pointer(pc),
    .code_bank(bank), .proc_status(ps), .port_dir(dir),
    .seq_busy(busy), .handler_go(go)
  );
  iack_cpu_model iack_cpu_model_inst
  (
    .sys_clk(sys_clk), .rst(rst), .step(step), .pin_lvl(pin_lvl),
    .ext_irq_pin(pins), .fetch_strb(fetch), .instr_done(done)
  );

  ////////////////////////////////////////////////////////////////////////////
  always #10 sys_clk = ~sys_clk;
  // hang guard, far above the several hundred cycles the run needs
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      mismatches++;
      summarize();
    end
  end

  function automatic logic [15:0] ctl(logic s, logic p, logic [2:0] l);
    return {10'h000, s, p, 1'b0, l};
  endfunction
  function automatic logic [8:0] madr(logic [6:0] b);
    return {1'b1, b[6:1], 2'b00};
  endfunction
  function automatic logic [8:0] ra(logic [6:0] a);
    return {a, 2'b00};
  endfunction
  function automatic logic [15:0] vec(int i);
    return 16'hA000 + 16'(i * 16'h0111);
  endfunction
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // request held up to the edge that samples ack; read data taken there
  task automatic wb(logic w, logic [8:0] a, logic [15:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {16'h0000, d};
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1)
    begin
      mismatches++;
      $display("mismatch %0t: no bus answer", $time);
    end
    q = dat_o[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge sys_clk);
  endtask
  // one fetch, count busy cycles up to the handler start, then refetch
  task automatic irq(logic wd, output int n);
    n = 0;
    step <= 1'b1;
    wdt <= wd;
    @(posedge sys_clk);
    step <= 1'b0;
    wdt <= 1'b0;
    for (int k = 0; k < 40 && go !== 1'b1; k++)
    begin
      @(negedge sys_clk);
      if (busy === 1'b1)
        n++;
    end
    @(posedge sys_clk);
    step <= 1'b1;
    @(posedge sys_clk);
    step <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic summarize();
    if (mismatches == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(50008));
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk(ps, `IACK_PSW_RST);
    for (int i = 0; i < 6; i++)
      wb(1'b1, madr(7'(2 * i)), vec(i));
    // direction bits follow a random write, then go to zero for the pins
    lvl = 3'($urandom);
    wb(1'b1, ra(`IACK_A_DIR), {13'h0000, lvl});
    chk({13'h0000, dir}, {13'h0000, lvl});
    wb(1'b1, ra(`IACK_A_DIR), 16'h0000);
    chk({13'h0000, dir}, 16'h0000);
    wb(1'b0, ra(7'h07), 16'h0000);
    chk(q, 16'h0000);
    // even then odd stack pointer, level one above the threshold
    for (int i = 0; i < 2; i++)
    begin
      pin_lvl <= {2'($urandom), 1'b0};
      sp0 = 7'h40 + 7'(i);
      pc0 = 16'($urandom);
      bk0 = 8'($urandom);
      lvl = 3'($urandom_range(7, 1));
      stk = '{bk0, pc0[15:8], pc0[7:0], {5'h00, lvl - 3'h1}, 8'h00};
      wb(1'b1, ra(`IACK_A_SP), {9'h000, sp0});
      wb(1'b1, ra(`IACK_A_PC), pc0);
      wb(1'b1, ra(`IACK_A_BANK), {8'h00, bk0});
      wb(1'b1, ra(`IACK_A_PSW), {stk[3], stk[4]});
      wb(1'b1, ra(`IACK_A_EXT0), ctl(1'b0, 1'b1, lvl));
      pin_lvl[0] <= 1'b1;
      repeat (5) @(posedge sys_clk);
      wb(1'b0, ra(`IACK_A_EXT0), 16'h0000);
      chk(q, ctl(1'b0, 1'b1, lvl) | 16'h0008);
      wb(1'b0, ra(`IACK_A_PORT), 16'h0000);
      chk(q, {13'h0000, pin_lvl});
      irq(1'b0, nb);
      chk(16'(nb), 16'h000D);
      chk(pc, vec(0));
      chk({8'h00, bank}, {8'h00, `IACK_BANK_CLR});
      chk(ps, {5'h00, lvl, 8'h40});
      wb(1'b0, ra(`IACK_A_EXT0), 16'h0000);
      chk(q, ctl(1'b0, 1'b1, lvl));
      wb(1'b0, ra(`IACK_A_SP), 16'h0000);
      chk(q, {9'h000, sp0 - 7'h05});
      for (int j = 0; j < 5; j++)
      begin
        wb(1'b0, madr(sp0 - 7'(j)), 16'h0000);
        chk(16'((sp0[0] ^ j[0]) ? q[15:8] : q[7:0]), 16'(stk[j]));
      end
      wb(1'b1, ra(`IACK_A_CMD), 16'h0001);
      repeat (15) @(posedge sys_clk);
      chk(pc, pc0);
      chk({8'h00, bank}, {8'h00, bk0});
      chk(ps, {stk[3], stk[4]});
    end
    // pin 1 at level 3 is held off by threshold 5, then wins at 2
    wb(1'b1, ra(`IACK_A_PSW), 16'h0500);
    pin_lvl <= 3'h7;
    repeat (5) @(posedge sys_clk);
    wb(1'b1, ra(7'h09), ctl(1'b0, 1'b0, 3'h3));
    pin_lvl[1] <= 1'b0;
    repeat (5) @(posedge sys_clk);
    irq(1'b0, nb);
    chk(16'(nb), 16'h0000);
    wb(1'b1, ra(`IACK_A_PSW), 16'h0200);
    irq(1'b0, nb);
    chk(16'(nb), 16'h000D);
    chk(pc, vec(1));
    // handler opens up; pin 2 senses a high level at level 6
    wb(1'b1, ra(`IACK_A_PSW), 16'h0300);
    wb(1'b1, ra(7'h0A), ctl(1'b1, 1'b0, 3'h6));
    pin_lvl[2] <= 1'b0;
    repeat (5) @(posedge sys_clk);
    irq(1'b0, nb);
    chk(16'(nb), 16'h0000);
    pin_lvl[2] <= 1'b1;
    repeat (5) @(posedge sys_clk);
    irq(1'b0, nb);
    chk(16'(nb), 16'h000D);
    chk(pc, vec(2));
    chk(ps, 16'h0640);
    wb(1'b1, ra(`IACK_A_CMD), 16'h0001);
    repeat (15) @(posedge sys_clk);
    chk(ps, 16'h0300);
    // zero-division then break: both beat the pending pin, keep threshold
    for (int t = 0; t < 2; t++)
    begin
      {break_trap, zdiv} <= 2'(1 << t);
      @(posedge sys_clk);
      {break_trap, zdiv} <= 2'h0;
      irq(1'b0, nb);
      chk(16'(nb), 16'h000D);
      chk(pc, vec(4 + t));
      chk(ps, 16'h0340);
      wb(1'b1, ra(`IACK_A_CMD), 16'h0001);
      repeat (15) @(posedge sys_clk);
    end
    irq(1'b1, nb);
    chk(pc, vec(3));
    chk(ps, 16'h0740);
    summarize();
  end
endmodule

// ### verilog/iack_consts.svh
// constants for the interrupt acknowledge block
`ifndef IACK_CONSTS_SVH
`define IACK_CONSTS_SVH
`define IACK_A_PSW     7'h00
`define IACK_A_BANK    7'h01
`define IACK_A_PC      7'h02
`define IACK_A_SP      7'h03
`define IACK_A_CMD     7'h04
`define IACK_A_PORT    7'h05
`define IACK_A_DIR     7'h06
`define IACK_A_EXT0    7'h08
`define IACK_MEM_BIT   8
`define IACK_B_IFLAG   6
`define IACK_B_IPL     10:8
`define IACK_B_LVL     2:0
`define IACK_B_REQ     3
`define IACK_B_POL     4
`define IACK_B_SENSE   5
`define IACK_B_RTI     0
`define IACK_PSW_RST   16'h0040
`define IACK_SP_RST    7'h7F
`define IACK_IPL_WDT   3'h7
`define IACK_BANK_CLR  8'h00
`define IACK_SEQ_MIN   4'hD
`define IACK_LAST_BYTE 3'h4
`define IACK_WORD_K1   3'h1
`define IACK_WORD_K2   3'h3
`define IACK_SRC_WDT   3'h3
`define IACK_SRC_ZDIV  3'h4
`define IACK_SRC_BRK   3'h5
`define IACK_MEM_DEPTH 64
`define IACK_MA_W      6
`endif

// ### verilog/iack_ctrl.sv
// interrupt acceptance, acknowledge sequence and external pin sensing
`timescale 1ns/100ps
`include "iack_consts.svh"
//////////////////////////////////////////////////////////////////////////////
// Contract
// [RULE1] accepting a request clears that source's request flag
// [RULE2] sequence starts the cycle after the current instruction completes
// [RULE3] push bank, pc, status; set disable; load threshold; bank 0; vector
// [RULE4] handler start address is a 16-bit address in bank zero
// [RULE5] acknowledge sequence lasts at least 13 clock cycles
// [RULE6] maskable acceptance loads threshold with accepted level
// [RULE7] threshold 0 at reset, 7 on watchdog, unchanged on traps
// [RULE8] even stack pointer pushes pc and status as words, odd as bytes
// [RULE9] hardware stacks only bank, pc and status word
// [RULE10] return pops status, pc and bank, then resumes
// [RULE11] refused requests stay pending and win after threshold restores
// [RULE12] handler may clear disable flag to allow higher level nesting
// [RULE13] sense and polarity bits pick falling, rising, high or low
// [RULE14] pins are watched always; level zero silences an unused pin
// [RULE15] edge sets flag until accepted; software may clear or set it
// [RULE16] level mode ignores the flag and requests while pin valid
// [RULE17] level request vanishes if pin goes inactive before acceptance
// [RULE18] software clears flag after changing sense or polarity
// [RULE19] software sets direction bits to zero for interrupt pins
// [RULE20] port data register still reads the pin states
// [RULE21] accept only when enabled, requested and level above threshold
// [RULE22] levels 1 to 7 rank sources; level 0 disables a source
// [RULE23] threshold lives in status bits 8 to 10
// [RULE24] each source has its own vector word
// [RULE25] no detection during the sequence until handler's first fetch
module iack_ctrl
(
  input  wire logic            sys_clk,
  input  wire logic            rst,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [8:0]      wb_adr_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic [31:0]          wb_dat_o,
  output logic                 wb_ack_o,
  input  wire logic [2:0]      ext_irq_pin,
  input  wire logic            fetch_strb,
  input  wire logic            instr_done,
  input  wire logic            wdt_irq,
  input  wire logic            zdiv_trap,
  input  wire logic            brk_trap,
  output iack_pkg::iack_word_t code_pointer,
  output logic [7:0]           code_bank,
  output iack_pkg::iack_word_t proc_status,
  output logic [2:0]           port_dir,
  output logic                 seq_busy,
  output logic                 handler_go
);
  import iack_pkg::*;

  iack_mem_if mem ();
  iack_state_t state_reg, state_next;
  logic [2:0]  pin_s1_reg, pin_s2_reg, pin_d_reg;
  logic [2:0]  trap_reg, dir_reg, k_reg, acc_src_reg, acc_ipl_reg;
  logic [5:0]  snap_reg;
  logic [8:0]  snap_lvl_reg;
  logic [3:0]  cnt_reg;
  logic [6:0]  sp_reg;
  logic [7:0]  bank_reg;
  logic [15:0] psw_reg, pc_reg;
  logic        wide_reg, vec_rd_reg, vec_got_reg;
  logic        ack_reg, mpend_reg, go_reg, busy_reg;
  logic [31:0] dat_reg;
  logic [2:0]  best_src;
  logic [2:0]  best_lvl;
  wire  logic [2:0]  eff_req;
  wire  logic [8:0]  lvl_pk;
  wire  logic [15:0] ext_rd [3];

  //////////////////////////////////////////////////////////////////////////
  // wishbone decode
  wire logic [6:0] adr_w   = wb_adr_i[8:2];
  wire logic bus_req = wb_cyc_i & wb_stb_i & ~ack_reg & ~mpend_reg;
  wire logic mem_hit = wb_adr_i[`IACK_MEM_BIT];
  wire logic reg_go  = bus_req & ~mem_hit;
  wire logic reg_wr  = reg_go & wb_we_i;
  wire logic idle_w  = state_reg == IACK_IDLE;
  // memory is lent to the bus only while the sequencer leaves it alone
  wire logic mem_free = idle_w | (state_reg == IACK_DET)
                      | (state_reg == IACK_HOLD);
  wire logic mem_go  = bus_req & mem_hit & mem_free;

  // every operand is an argument, so continuous users re-evaluate on change
  function automatic logic wr_hit(input logic go, input logic [6:0] adr,
                                  input logic [6:0] a);
    wr_hit = go && (adr == a);
  endfunction

  function automatic logic [15:0] wmerge(input logic [15:0] old);
    wmerge = {wb_sel_i[1] ? wb_dat_i[15:8] : old[15:8],
              wb_sel_i[0] ? wb_dat_i[7:0]  : old[7:0]};
  endfunction

  // cpu state is only written by software while no sequence runs
  wire logic sw_psw  = wr_hit(reg_wr, adr_w, `IACK_A_PSW) & idle_w;
  wire logic sw_pc   = wr_hit(reg_wr, adr_w, `IACK_A_PC) & idle_w;
  wire logic sw_bank = wr_hit(reg_wr, adr_w, `IACK_A_BANK) & idle_w
                     & wb_sel_i[0];
  wire logic sw_sp   = wr_hit(reg_wr, adr_w, `IACK_A_SP) & idle_w
                     & wb_sel_i[0];
  wire logic rti_go  = wr_hit(reg_wr, adr_w, `IACK_A_CMD) & idle_w
                     & wb_sel_i[0] & wb_dat_i[`IACK_B_RTI];
  wire logic [2:0] ipl_w = psw_reg[`IACK_B_IPL]; // [RULE23]

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the third stage feeds the edge detectors
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_s1_reg <= 3'h0;
      pin_s2_reg <= 3'h0;
      pin_d_reg  <= 3'h0;
    end
    else
    begin
      pin_s1_reg <= ext_irq_pin;
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg  <= pin_s2_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // acceptance decision, evaluated on the latched snapshot
  wire logic mask_ok = ~psw_reg[`IACK_B_IFLAG] & (best_lvl > ipl_w); // [RULE21]
  wire logic acc_w = (state_reg == IACK_DET)
                   & ((snap_reg[5:3] != 3'h0) | mask_ok);
  wire logic [2:0] win_src = snap_reg[3] ? `IACK_SRC_WDT
                           : snap_reg[4] ? `IACK_SRC_ZDIV
                           : snap_reg[5] ? `IACK_SRC_BRK : best_src;
  // watchdog forces 7, traps keep the threshold, others take their level
  wire logic [2:0] win_ipl = snap_reg[3] ? `IACK_IPL_WDT // [RULE7]
                           : (snap_reg[5:4] != 2'h0) ? ipl_w
                           : best_lvl; // [RULE6]
  wire logic [5:0] clr_w = acc_w ? (6'h01 << win_src) : 6'h00; // [RULE1]

  // ties go to the higher pin number; a zero level never beats the threshold
  always_comb
  begin
    best_src = 3'h0;
    best_lvl = 3'h0;
    for (int i = 0; i < 3; i++)
    begin
      if (snap_reg[i] && (snap_lvl_reg[3*i +: 3] >= best_lvl)) // [RULE22]
      begin
        best_src = 3'(i);
        best_lvl = snap_lvl_reg[3*i +: 3];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // external pins: one control register each
  for (genvar i = 0; i < 3; i++)
  begin : g_ext
    logic [2:0] lvl_reg;
    logic       req_reg, pol_reg, sns_reg;
    wire logic wr   = wr_hit(reg_wr, adr_w, `IACK_A_EXT0 + 7'(i))
                    & wb_sel_i[0];
    wire logic rise = pin_s2_reg[i] & ~pin_d_reg[i];
    wire logic fall = ~pin_s2_reg[i] & pin_d_reg[i];
    wire logic edge_hit = ~sns_reg & (pol_reg ? rise : fall); // [RULE13]
    wire logic lvl_on   = pol_reg ? ~pin_s2_reg[i] : pin_s2_reg[i];
    // a fresh edge wins over a software or acceptance clear
    wire logic req_next = edge_hit // [RULE15]
                        | (wr ? wb_dat_i[`IACK_B_REQ] : req_reg & ~clr_w[i]);
    always_ff @(posedge sys_clk or posedge rst)
    begin
      if (rst)
      begin
        req_reg <= 1'b0;
        lvl_reg <= 3'h0;
        pol_reg <= 1'b0;
        sns_reg <= 1'b0;
      end
      else
      begin
        req_reg <= req_next;
        if (wr)
        begin
          lvl_reg <= wb_dat_i[`IACK_B_LVL];
          pol_reg <= wb_dat_i[`IACK_B_POL];
          sns_reg <= wb_dat_i[`IACK_B_SENSE];
        end
      end
    end
    // level mode follows the pin and drops out with it
    assign eff_req[i] = sns_reg ? lvl_on : req_reg; // [RULE16] [RULE17] [RULE14]
    assign lvl_pk[3*i +: 3] = lvl_reg;
    assign ext_rd[i] = {10'h000, sns_reg, pol_reg, req_reg, lvl_reg};
  end

  //////////////////////////////////////////////////////////////////////////
  // trap and watchdog pending flags, new pulse beats the clear
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      trap_reg <= 3'h0;
    else
      trap_reg <= {brk_trap, zdiv_trap, wdt_irq} | (trap_reg & ~clr_w[5:3]);
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer stepping
  wire logic wordw = wide_reg & ((k_reg == `IACK_WORD_K1)
                   | (k_reg == `IACK_WORD_K2)); // [RULE8]
  wire logic [2:0] k_nxt = k_reg + (wordw ? 3'h2 : 3'h1);
  wire logic push_last = (state_reg == IACK_PUSH) & (k_nxt > `IACK_LAST_BYTE);
  wire logic vec_cap = (state_reg == IACK_VECT) & vec_rd_reg & ~vec_got_reg;
  wire logic [6:0] pop_a = sp_reg + 7'h01;
  wire logic [7:0] pop_b = pop_a[0] ? mem.rdata[15:8] : mem.rdata[7:0];
  // only bank, pc and status are stacked, highest byte first
  wire logic [7:0] pbyte [6];
  assign pbyte[0] = bank_reg; // [RULE9]
  assign pbyte[1] = pc_reg[15:8];
  assign pbyte[2] = pc_reg[7:0];
  assign pbyte[3] = psw_reg[15:8];
  assign pbyte[4] = psw_reg[7:0];
  assign pbyte[5] = 8'h00;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      IACK_IDLE: if (rti_go) state_next = IACK_POP;
                 else if (fetch_strb) state_next = IACK_DET;
      IACK_DET:  state_next = acc_w ? IACK_HOLD : IACK_IDLE; // [RULE11]
      IACK_HOLD: if (instr_done) state_next = IACK_PUSH; // [RULE2]
      IACK_PUSH: if (push_last) state_next = IACK_VECT;
      IACK_VECT: if (vec_got_reg && cnt_reg >= `IACK_SEQ_MIN) // [RULE5]
                   state_next = IACK_DONE;
      IACK_DONE: if (fetch_strb) state_next = IACK_IDLE; // [RULE25]
      IACK_POP:  state_next = IACK_POPW;
      IACK_POPW: if (k_reg == `IACK_LAST_BYTE) state_next = IACK_IDLE;
                 else state_next = IACK_POP;
    endcase
  end

  // state, snapshot and bookkeeping of the accepted source
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= IACK_IDLE;
      snap_reg <= 6'h00;
      snap_lvl_reg <= 9'h000;
      acc_src_reg <= 3'h0;
      acc_ipl_reg <= 3'h0;
      wide_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (idle_w && fetch_strb)
      begin
        snap_reg <= {trap_reg, eff_req};
        snap_lvl_reg <= lvl_pk;
      end
      if (acc_w)
      begin
        acc_src_reg <= win_src;
        acc_ipl_reg <= win_ipl;
        wide_reg <= ~sp_reg[0]; // [RULE8]
      end
    end
  end

  // byte index, cycle count and vector fetch flags
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      k_reg <= 3'h0;
      cnt_reg <= 4'h0;
      vec_rd_reg <= 1'b0;
      vec_got_reg <= 1'b0;
    end
    else
    begin
      if (acc_w || rti_go) k_reg <= 3'h0;
      else if (state_reg == IACK_PUSH) k_reg <= k_nxt;
      else if (state_reg == IACK_POPW) k_reg <= k_reg + 3'h1;
      if (state_reg == IACK_HOLD) cnt_reg <= 4'h1;
      else if (busy_reg) cnt_reg <= cnt_reg + 4'h1;
      vec_rd_reg <= (state_reg == IACK_VECT);
      vec_got_reg <= (state_reg == IACK_VECT) & (vec_got_reg | vec_cap);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // cpu state touched by the sequence: pushes, loads and pops
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      psw_reg <= `IACK_PSW_RST; // [RULE7]
      pc_reg <= 16'h0000;
      bank_reg <= `IACK_BANK_CLR;
      sp_reg <= `IACK_SP_RST;
    end
    else
    begin
      if (state_reg == IACK_PUSH) sp_reg <= sp_reg - (wordw ? 7'h02 : 7'h01);
      else if (state_reg == IACK_POPW) sp_reg <= pop_a; // [RULE10]
      else if (sw_sp) sp_reg <= wb_dat_i[6:0];
      if (push_last) // [RULE3]
      begin
        psw_reg[`IACK_B_IFLAG] <= 1'b1; // [RULE12]
        psw_reg[`IACK_B_IPL] <= acc_ipl_reg; // [RULE6]
        bank_reg <= `IACK_BANK_CLR;
      end
      else if (state_reg == IACK_POPW)
        unique case (k_reg)
          3'h0: psw_reg[7:0] <= pop_b;
          3'h1: psw_reg[15:8] <= pop_b;
          3'h2: pc_reg[7:0] <= pop_b;
          3'h3: pc_reg[15:8] <= pop_b;
          default: bank_reg <= pop_b;
        endcase
      else
      begin
        if (sw_psw) psw_reg <= wmerge(psw_reg); // [RULE12]
        if (sw_bank) bank_reg <= wb_dat_i[7:0];
        if (sw_pc) pc_reg <= wmerge(pc_reg);
      end
      if (vec_cap) pc_reg <= mem.rdata; // [RULE4] [RULE24]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // memory port: sequencer first, bus in the gaps
  assign mem.en = (state_reg == IACK_PUSH) | (state_reg == IACK_POP)
                | ((state_reg == IACK_VECT) & ~vec_rd_reg) | mem_go;
  assign mem.we = (state_reg == IACK_PUSH)
                ? (wordw ? 2'h3 : (sp_reg[0] ? 2'h2 : 2'h1))
                : (mem_go & wb_we_i) ? wb_sel_i[1:0] : 2'h0;
  assign mem.addr = (state_reg == IACK_PUSH) ? sp_reg[6:1]
                  : (state_reg == IACK_VECT) ? {3'h0, acc_src_reg}
                  : (state_reg == IACK_POP) ? pop_a[6:1] : wb_adr_i[7:2];
  assign mem.wdata = (state_reg == IACK_PUSH)
                   ? (wordw ? {pbyte[k_reg], pbyte[k_nxt - 3'h1]}
                            : {pbyte[k_reg], pbyte[k_reg]})
                   : wb_dat_i[15:0];

  iack_ram u_ram
  (
    .sys_clk (sys_clk),
    .m       (mem.ram)
  );

  //////////////////////////////////////////////////////////////////////////
  // register read selection; unmapped words read zero
  wire logic [15:0] rd_mux =
      (adr_w == `IACK_A_PSW)  ? psw_reg
    : (adr_w == `IACK_A_BANK) ? {8'h00, bank_reg}
    : (adr_w == `IACK_A_PC)   ? pc_reg
    : (adr_w == `IACK_A_SP)   ? {9'h000, sp_reg}
    : (adr_w == `IACK_A_CMD)  ? {13'h0000, state_reg}
    : (adr_w == `IACK_A_PORT) ? {13'h0000, pin_s2_reg} // [RULE20]
    : (adr_w == `IACK_A_DIR)  ? {13'h0000, dir_reg}
    : (adr_w == `IACK_A_EXT0) ? ext_rd[0]
    : (adr_w == `IACK_A_EXT0 + 7'h01) ? ext_rd[1]
    : (adr_w == `IACK_A_EXT0 + 7'h02) ? ext_rd[2] : 16'h0000;

  // registers answer in one cycle, memory in two
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ack_reg <= 1'b0;
      mpend_reg <= 1'b0;
      dat_reg <= 32'h00000000;
      dir_reg <= 3'h0;
      go_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= reg_go | mpend_reg;
      mpend_reg <= mem_go;
      if (mpend_reg) dat_reg <= {16'h0000, mem.rdata};
      else if (reg_go) dat_reg <= {16'h0000, rd_mux};
      if (wr_hit(reg_wr, adr_w, `IACK_A_DIR) && wb_sel_i[0])
        dir_reg <= wb_dat_i[2:0];
      go_reg <= (state_reg == IACK_VECT) & (state_next == IACK_DONE);
      busy_reg <= (state_next == IACK_PUSH) | (state_next == IACK_VECT);
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign code_pointer = pc_reg;
  assign code_bank = bank_reg;
  assign proc_status = psw_reg;
  assign port_dir = dir_reg;
  assign seq_busy = busy_reg;
  assign handler_go = go_reg;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence push_end_s;
    push_last;
  endsequence
  sequence loaded_s;
    psw_reg[`IACK_B_IFLAG] && (ipl_w == acc_ipl_reg) && (bank_reg == 8'h00);
  endsequence

  trap_clear_a: assert property (acc_w && win_src == `IACK_SRC_ZDIV // [RULE1]
    && !zdiv_trap |=> !trap_reg[1]) else $error("accepted trap stays set");
  seq_start_a: assert property ((state_reg == IACK_HOLD) && instr_done // [RULE2]
    |=> seq_busy && (state_reg == IACK_PUSH)) else $error("late start");
  seq_order_a: assert property (push_end_s |=> loaded_s ##0 // [RULE3]
    (state_reg == IACK_VECT)) else $error("acknowledge order broken");
  go_bank_a: assert property (handler_go |-> code_bank == 8'h00 // [RULE4]
    && !seq_busy) else $error("handler not in bank zero");
  seq_len_a: assert property ($rose(seq_busy) |-> // [RULE5]
    (seq_busy && !handler_go) [*8] ##1 (seq_busy && !handler_go) [*5]
    ##1 !seq_busy && handler_go) else $error("sequence length wrong");
  wdt_ipl_a: assert property (acc_w && snap_reg[3] |=> // [RULE7]
    acc_ipl_reg == `IACK_IPL_WDT) else $error("watchdog threshold wrong");
  word_push_a: assert property ((state_reg == IACK_PUSH) && wide_reg // [RULE8]
    && (k_reg == `IACK_WORD_K1) |-> mem.we == 2'h3) else $error("no word push");
  masked_a: assert property ((state_reg == IACK_DET) && snap_reg[5:3] == 3'h0 // [RULE21]
    && psw_reg[`IACK_B_IFLAG] |=> idle_w) else $error("masked accept");
  rise_set_a: assert property (!g_ext[0].sns_reg && g_ext[0].pol_reg // [RULE15]
    && g_ext[0].rise |=> g_ext[0].req_reg) else $error("edge lost");
  hold_done_a: assert property ((state_reg == IACK_DONE) && !fetch_strb // [RULE25]
    |=> state_reg == IACK_DONE) else $error("early detection");
  pop_end_a: assert property ((state_reg == IACK_POPW) // [RULE10]
    && (k_reg == `IACK_LAST_BYTE) |=> idle_w && (sp_reg == $past(pop_a)))
    else $error("return did not finish");
endmodule

// ### verilog/iack_mem_if.sv
// port bundle between the sequencer and its vector and stack memory
`timescale 1ns/100ps
`include "iack_consts.svh"
interface iack_mem_if;
  logic                  en;
  logic [1:0]            we;
  logic [`IACK_MA_W-1:0] addr;
  logic [15:0]           wdata;
  logic [15:0]           rdata;
  modport ctl (output en, we, addr, wdata, input rdata);
  modport ram (input en, we, addr, wdata, output rdata);
endinterface

// ### verilog/iack_pkg.sv
// types shared by the interrupt acknowledge block
package iack_pkg;
  typedef enum logic [2:0]
  {
    IACK_IDLE = 3'h0,
    IACK_DET  = 3'h1,
    IACK_HOLD = 3'h3,
    IACK_PUSH = 3'h2,
    IACK_VECT = 3'h6,
    IACK_DONE = 3'h7,
    IACK_POPW = 3'h5,
    IACK_POP  = 3'h4
  } iack_state_t;
  typedef logic [15:0] iack_word_t;
endpackage

// ### verilog/iack_ram.sv
// byte-lane memory holding the vector table and the hardware stack
`timescale 1ns/100ps
`include "iack_consts.svh"
module iack_ram
(
  input wire logic sys_clk,
  iack_mem_if.ram  m
);
  import iack_pkg::*;

  // one array per byte lane so that each lane has a single writer
  for (genvar b = 0; b < 2; b++)
  begin : g_lane
    logic [7:0] mem_reg [`IACK_MEM_DEPTH];
    logic [7:0] q_reg;
    always_ff @(posedge sys_clk)
    begin
      if (m.en && m.we[b])
        mem_reg[m.addr] <= m.wdata[8*b +: 8];
    end
    // read data only moves on a pure read, so writes never disturb it
    always_ff @(posedge sys_clk)
    begin
      if (m.en && (m.we == 2'h0))
        q_reg <= mem_reg[m.addr];
    end
    assign m.rdata[8*b +: 8] = q_reg;
  end
endmodule
